// ===== design/host_buffer_pkg.sv
// Constants shared by the host buffer controller and its word buffers
package host_buffer_pkg;

  // ==========================================================================
  // Data path sizes
  localparam int WORD_W = 32;
  localparam int BUF_BITS = 4096;
  localparam int BUF_DEPTH = BUF_BITS / WORD_W;
  localparam int ADDR_W = 12;
  localparam int EU_IRQ_W = 5;

  // ==========================================================================
  // Host word addresses of the controller registers
  localparam logic [ADDR_W-1:0] OFS_INPUT_BUF = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_BUF = 12'h001;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONFIG = 12'h002;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h003;
  localparam logic [ADDR_W-1:0] OFS_INPUT_COUNT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_COUNT = 12'h005;

  // ==========================================================================
  // controller_status_config fields
  localparam int BIT_ROUTE_ONE = 0;
  localparam int BIT_ROUTE_TWO = 1;
  localparam int BIT_IN_ACTIVE = 2;
  localparam int BIT_OUT_ACTIVE = 3;
  localparam int BIT_BUS_STYLE = 4;
  localparam int POS_EU_IRQ = 8;
  localparam logic ROUTE_INPUT = 1'b0;
  localparam logic ROUTE_OUTPUT = 1'b1;
  localparam logic ROUTE_ONE_RESET = ROUTE_INPUT;
  localparam logic ROUTE_TWO_RESET = ROUTE_OUTPUT;
  localparam logic [EU_IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;
  localparam logic [WORD_W-1:0] COUNT_RESET = 32'h0000_0000;

  // ==========================================================================
  // Bus style pin and burst handling
  localparam logic BUS_STYLE_SINGLE = 1'b0;
  localparam logic BUS_STYLE_BURST = 1'b1;
  localparam int BURST_LEN = 8;
  localparam int DMA_THRESH = 8;
  localparam int BEAT_W = 4;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_BURST_WR = 2'b01,
    HOST_BURST_RD = 2'b10
  } host_state_t;

endpackage : host_buffer_pkg

// ===== design/word_buffer.sv
// Flip-flop word buffer with valid/ready on both sides and a fill level
`timescale 1ns/10ps
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 128
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pushValid,
  output logic pushReady,
  input wire logic [WIDTH-1:0] pushData,
  output logic popValid,
  input wire logic popReady,
  output logic [WIDTH-1:0] popData,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int LVL_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [LVL_W-1:0] level_reg;
  logic doPush;
  logic doPop;

  // ==========================================================================
  // Handshakes
  assign pushReady = level_reg != LVL_FULL;
  assign popValid = level_reg != '0;
  assign doPush = pushValid && pushReady;
  assign doPop = popValid && popReady;
  assign popData = store_reg[rdPtr_reg];
  assign level = level_reg;

  // ==========================================================================
  // Storage, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      store_reg[wrPtr_reg] <= pushData;
    end
  end

  // Pointers wrap explicitly so DEPTH need not be a power of two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_reg <= '0;
    end else if (doPush && !doPop) begin
      level_reg <= level_reg + 1'b1;
    end else if (doPop && !doPush) begin
      level_reg <= level_reg - 1'b1;
    end
  end

endmodule : word_buffer
`default_nettype wire

// ===== design/host_buffer_fifo_controller.sv
// Host buffer controller: word buffers, transfer counts, DMA requests, interrupt gathering
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Input count sets words sent to unit
// - Input counter decrements; stops at zero
// - Output count sets words taken from unit
// - Unit interrupts gathered onto host interrupt
// - Static pin picks single or burst style
// - Bursts only to buffers, burst style only
// - Burst style bursts are always eight words
// - Two 4096-bit buffers, host or DMA access
// - Each DMA request routable to either buffer
// - Reset routing: one input, two output
// - Input request when eight words free
// - Output request while eight words waiting
// - Counts programmed first, end unit transfers
module host_buffer_fifo_controller
  import host_buffer_pkg::*;
#(
  parameter int BufDepth = host_buffer_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic busStyle,
  input wire logic hostReq,
  input wire logic hostWrite,
  input wire logic hostBurst,
  input wire logic [host_buffer_pkg::ADDR_W-1:0] hostAddr,
  input wire logic [host_buffer_pkg::WORD_W-1:0] hostWdata,
  output logic hostAck,
  output logic hostRefused,
  output logic hostRvalid,
  output logic [host_buffer_pkg::WORD_W-1:0] hostRdata,
  output logic dmaRequestOneN,
  output logic dmaRequestTwoN,
  output logic euInValid,
  output logic [host_buffer_pkg::WORD_W-1:0] euInData,
  input wire logic euInReady,
  input wire logic euOutValid,
  input wire logic [host_buffer_pkg::WORD_W-1:0] euOutData,
  output logic euOutReady,
  input wire logic [host_buffer_pkg::EU_IRQ_W-1:0] euIrq,
  output logic irqN
);
  import host_buffer_pkg::*;

  localparam int LVL_W = $clog2(BufDepth + 1);
  localparam logic [LVL_W-1:0] LVL_DEPTH = LVL_W'(BufDepth);
  localparam logic [LVL_W-1:0] LVL_THRESH = LVL_W'(DMA_THRESH);
  localparam logic [BEAT_W-1:0] BEATS_AFTER_FIRST = BEAT_W'(BURST_LEN - 1);
  localparam logic [BEAT_W-1:0] BEAT_LAST = BEAT_W'(1);

  // ==========================================================================
  // Declarations
  host_state_t state_reg;
  host_state_t state_next;
  logic [BEAT_W-1:0] beatCnt_reg;
  logic [BEAT_W-1:0] beatCnt_next;
  logic [WORD_W-1:0] inCount_reg;
  logic [WORD_W-1:0] outCount_reg;
  logic routeOne_reg;
  logic routeTwo_reg;
  logic [EU_IRQ_W-1:0] irqMask_reg;
  logic hostRvalid_reg;
  logic [WORD_W-1:0] hostRdata_reg;
  logic styleBurst_reg;

  logic inBurst;
  logic isInBuf;
  logic isOutBuf;
  logic burstAllowed;
  logic dirOk;
  logic badBurst;
  logic beatWrite;
  logic beatIn;
  logic beatOut;
  logic wantPush;
  logic wantPop;
  logic stallHost;
  logic regWrite;
  logic inPush;
  logic outPop;
  logic inPushReady;
  logic inPopValid;
  logic inXfer;
  logic outPushReady;
  logic outPopValid;
  logic outXfer;
  logic [WORD_W-1:0] outPopData;
  logic [LVL_W-1:0] inLevel;
  logic [LVL_W-1:0] outLevel;
  logic inSpaceReady;
  logic outDataReady;
  logic [WORD_W-1:0] statusWord;
  logic [WORD_W-1:0] readMux;

  // ==========================================================================
  // Buffers, 4096 bits each
  word_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(BufDepth)
  ) inputBuffer (
    .clk_sys(clk_sys),
    .rst(rst),
    .pushValid(inPush),
    .pushReady(inPushReady),
    .pushData(hostWdata),
    .popValid(inPopValid),
    .popReady(euInReady && inCount_reg != '0),
    .popData(euInData),
    .level(inLevel)
  );

  word_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(BufDepth)
  ) outputBuffer (
    .clk_sys(clk_sys),
    .rst(rst),
    .pushValid(euOutValid && outCount_reg != '0),
    .pushReady(outPushReady),
    .pushData(euOutData),
    .popValid(outPopValid),
    .popReady(outPop),
    .popData(outPopData),
    .level(outLevel)
  );

  // ==========================================================================
  // Host access decode
  assign inBurst = state_reg != HOST_IDLE;
  assign isInBuf = hostAddr == OFS_INPUT_BUF;
  assign isOutBuf = hostAddr == OFS_OUTPUT_BUF;
  // Bursts follow the buffer's flow, so a read burst never starts on the input side
  assign dirOk = (isInBuf && hostWrite) || (isOutBuf && !hostWrite);
  assign burstAllowed = styleBurst_reg && dirOk;
  assign badBurst = !inBurst && hostReq && hostBurst && !burstAllowed;
  // Inside a burst the address and burst flag are ignored; the burst owns the buffer
  assign beatWrite = inBurst ? (state_reg == HOST_BURST_WR) : hostWrite;
  assign beatIn = inBurst ? (state_reg == HOST_BURST_WR) : isInBuf;
  assign beatOut = inBurst ? (state_reg == HOST_BURST_RD) : isOutBuf;
  assign wantPush = hostReq && beatWrite && beatIn;
  assign wantPop = hostReq && !beatWrite && beatOut;
  // Waiting on a full or empty buffer holds the host rather than losing words
  assign stallHost = (wantPush && !inPushReady) || (wantPop && !outPopValid);
  assign hostAck = hostReq && !badBurst && !stallHost;
  assign hostRefused = badBurst;
  assign inPush = hostAck && wantPush;
  assign outPop = hostAck && wantPop;
  assign regWrite = hostAck && beatWrite && !inBurst;

  // ==========================================================================
  // Bus style, taken only under reset
  // A pin moved in operation cannot change the protocol mid-transfer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      styleBurst_reg <= busStyle == BUS_STYLE_BURST;
    end
  end

  // ==========================================================================
  // Burst sequencing
  always_comb begin
    state_next = state_reg;
    beatCnt_next = beatCnt_reg;
    unique case (state_reg)
      HOST_IDLE: begin
        if (hostAck && hostBurst) begin
          state_next = hostWrite ? HOST_BURST_WR : HOST_BURST_RD;
          beatCnt_next = BEATS_AFTER_FIRST;
        end
      end
      HOST_BURST_WR, HOST_BURST_RD: begin
        if (hostAck) begin
          beatCnt_next = beatCnt_reg - 1'b1;
          if (beatCnt_reg == BEAT_LAST) begin
            state_next = HOST_IDLE;
          end
        end
      end
      default: begin
        state_next = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= HOST_IDLE;
      beatCnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      beatCnt_reg <= beatCnt_next;
    end
  end

  // ==========================================================================
  // Execution unit transfers, bounded by the word counts
  assign euInValid = inPopValid && inCount_reg != '0;
  assign inXfer = euInValid && euInReady;
  assign euOutReady = outPushReady && outCount_reg != '0;
  assign outXfer = euOutValid && euOutReady;

  // A host write to a count wins over a same-cycle decrement
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inCount_reg <= COUNT_RESET;
    end else if (regWrite && hostAddr == OFS_INPUT_COUNT) begin
      inCount_reg <= hostWdata;
    end else if (inXfer) begin
      inCount_reg <= inCount_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      outCount_reg <= COUNT_RESET;
    end else if (regWrite && hostAddr == OFS_OUTPUT_COUNT) begin
      outCount_reg <= hostWdata;
    end else if (outXfer) begin
      outCount_reg <= outCount_reg - 1'b1;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      routeOne_reg <= ROUTE_ONE_RESET;
      routeTwo_reg <= ROUTE_TWO_RESET;
    end else if (regWrite && hostAddr == OFS_STATUS_CONFIG) begin
      routeOne_reg <= hostWdata[BIT_ROUTE_ONE];
      routeTwo_reg <= hostWdata[BIT_ROUTE_TWO];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqMask_reg <= IRQ_MASK_RESET;
    end else if (regWrite && hostAddr == OFS_IRQ_MASK) begin
      irqMask_reg <= hostWdata[EU_IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // Interrupt gathering; a set mask bit blocks that unit
  assign irqN = ~|(euIrq & ~irqMask_reg);

  // ==========================================================================
  // DMA requests, purely from buffer levels and routing bits so they drop at once
  // Same eight-word thresholds in both bus styles
  assign inSpaceReady = (LVL_DEPTH - inLevel) >= LVL_THRESH;
  assign outDataReady = outLevel >= LVL_THRESH;
  assign dmaRequestOneN = ~((routeOne_reg == ROUTE_OUTPUT) ? outDataReady : inSpaceReady);
  assign dmaRequestTwoN = ~((routeTwo_reg == ROUTE_OUTPUT) ? outDataReady : inSpaceReady);

  // ==========================================================================
  // Read path
  always_comb begin
    statusWord = '0;
    statusWord[BIT_ROUTE_ONE] = routeOne_reg;
    statusWord[BIT_ROUTE_TWO] = routeTwo_reg;
    statusWord[BIT_IN_ACTIVE] = inCount_reg != '0;
    statusWord[BIT_OUT_ACTIVE] = outCount_reg != '0;
    statusWord[BIT_BUS_STYLE] = styleBurst_reg;
    statusWord[POS_EU_IRQ +: EU_IRQ_W] = euIrq;
  end

  always_comb begin
    readMux = '0;
    if (inBurst || isOutBuf) begin
      readMux = outPopData;
    end else if (hostAddr == OFS_STATUS_CONFIG) begin
      readMux = statusWord;
    end else if (hostAddr == OFS_IRQ_MASK) begin
      readMux = WORD_W'(irqMask_reg);
    end else if (hostAddr == OFS_INPUT_COUNT) begin
      readMux = inCount_reg;
    end else if (hostAddr == OFS_OUTPUT_COUNT) begin
      readMux = outCount_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hostRvalid_reg <= 1'b0;
      hostRdata_reg <= '0;
    end else begin
      hostRvalid_reg <= hostAck && !beatWrite;
      if (hostAck && !beatWrite) begin
        hostRdata_reg <= readMux;
      end
    end
  end

  assign hostRvalid = hostRvalid_reg;
  assign hostRdata = hostRdata_reg;

endmodule : host_buffer_fifo_controller
`default_nettype wire

// ===== bench/host_buffer_chk.sv
// Port-level checks of the host buffer controller
`timescale 1ns/10ps
`default_nettype none
module host_buffer_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic busStyle,
  input wire logic hostReq,
  input wire logic hostWrite,
  input wire logic hostBurst,
  input wire logic [host_buffer_pkg::ADDR_W-1:0] hostAddr,
  input wire logic [host_buffer_pkg::WORD_W-1:0] hostWdata,
  input wire logic hostAck,
  input wire logic hostRefused,
  input wire logic hostRvalid,
  input wire logic dmaRequestOneN,
  input wire logic dmaRequestTwoN,
  input wire logic euInValid,
  input wire logic euInReady,
  input wire logic euOutReady,
  input wire logic [host_buffer_pkg::EU_IRQ_W-1:0] euIrq,
  input wire logic irqN
);
  import host_buffer_pkg::*;
  logic [3:0] beatsLeft_reg;
  logic burstRead_reg;
  logic single;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Burst tracking, so single-access checks skip beats 2..8
  assign single = beatsLeft_reg == 4'h0;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      beatsLeft_reg <= 4'h0;
    end else if (hostReq && hostAck && !single) begin
      beatsLeft_reg <= beatsLeft_reg - 4'h1;
    end else if (hostReq && hostAck && hostBurst && busStyle) begin
      beatsLeft_reg <= 4'h7;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (hostReq && hostAck && single) begin
      burstRead_reg <= !hostWrite;
    end
  end

  // ==========================================================================
  // Properties
  property p_refuse_style;
    hostReq && hostBurst && !busStyle |-> hostRefused && !hostAck;
  endproperty
  a_refuse_style: assert property (p_refuse_style) else $error("burst taken in single style");
  property p_refuse_addr;
    single && hostReq && hostBurst && hostAddr > OFS_OUTPUT_BUF |-> hostRefused && !hostAck;
  endproperty
  a_refuse_addr: assert property (p_refuse_addr) else $error("burst to register taken");
  property p_read_answer;
    hostReq && hostAck && (single ? !hostWrite : burstRead_reg) |=> hostRvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read beat without data");
  property p_rvalid_cause;
    hostRvalid |-> $past(hostReq && hostAck);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("read data without beat");
  property p_in_stop;
    hostReq && hostAck && hostWrite && single && hostAddr == OFS_INPUT_COUNT
      && hostWdata == 32'h0 |=> !euInValid;
  endproperty
  a_in_stop: assert property (p_in_stop) else $error("input moves at zero count");
  property p_out_stop;
    hostReq && hostAck && hostWrite && single && hostAddr == OFS_OUTPUT_COUNT
      && hostWdata == 32'h0 |=> !euOutReady;
  endproperty
  a_out_stop: assert property (p_out_stop) else $error("output taken at zero count");
  property p_in_hold;
    euInValid && !euInReady |=> euInValid;
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("input word withdrawn");
  property p_irq_quiet;
    !(|euIrq) |-> irqN;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without source");
  property p_reset_route;
    $fell(rst) |-> !dmaRequestOneN && dmaRequestTwoN;
  endproperty
  a_reset_route: assert property (p_reset_route) else $error("wrong request routing");

  c_burst: cover property (!single && hostAck);
  c_refused: cover property (hostRefused);
  c_unit_in: cover property (euInValid && euInReady);
  c_irq: cover property (!irqN);
endmodule : host_buffer_chk
`default_nettype wire

// ===== bench/exec_unit_model.sv
// Execution unit stand-in: takes input words, returns them keyed
`timescale 1ns/10ps
`default_nettype none
module exec_unit_model #(
  parameter logic [31:0] XorKey = 32'h0f0f_a5a5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic stall,
  input wire logic euInValid,
  input wire logic [host_buffer_pkg::WORD_W-1:0] euInData,
  output logic euInReady,
  output logic euOutValid,
  output logic [host_buffer_pkg::WORD_W-1:0] euOutData,
  input wire logic euOutReady
);
  import host_buffer_pkg::*;
  logic [WORD_W-1:0] pend[$];
  // Idle data toggles so a stale word never looks valid
  always @(posedge clk_sys) begin
    if (rst) begin
      pend.delete();
      euInReady <= 1'b0;
      euOutValid <= 1'b0;
      euOutData <= 32'h0;
    end else begin
      euInReady <= !stall;
      if (euInValid && euInReady) pend.push_back(euInData ^ XorKey);
      if ((!euOutValid || euOutReady) && pend.size() != 0 && !stall) begin
        euOutValid <= 1'b1;
        euOutData <= pend.pop_front();
      end else if (!euOutValid || euOutReady) begin
        euOutValid <= 1'b0;
        euOutData <= ~euOutData;
      end
    end
  end
endmodule : exec_unit_model
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench of the host buffer controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import host_buffer_pkg::*;
  localparam logic [WORD_W-1:0] XorKey = 32'h0f0f_a5a5;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic busStyle = 1'b1;
  logic hostReq = 1'b0;
  logic hostWrite = 1'b0;
  logic hostBurst = 1'b0;
  logic [ADDR_W-1:0] hostAddr = 12'h000;
  logic [WORD_W-1:0] hostWdata = 32'h0;
  logic [EU_IRQ_W-1:0] euIrq = 5'h00;
  logic euStall = 1'b1;
  logic hostAck, hostRefused, hostRvalid, dmaRequestOneN, dmaRequestTwoN;
  logic euInValid, euInReady, euOutValid, euOutReady, irqN;
  logic [WORD_W-1:0] hostRdata, euInData, euOutData;
  logic [WORD_W-1:0] lfsrState = 32'h0001_527c;
  logic [WORD_W-1:0] inQ[$];
  int num_errors = 0;
  int checks_done = 0;

  host_buffer_fifo_controller dut_u (
    .clk_sys, .rst, .busStyle, .hostReq, .hostWrite, .hostBurst, .hostAddr, .hostWdata,
    .hostAck, .hostRefused, .hostRvalid, .hostRdata, .dmaRequestOneN, .dmaRequestTwoN,
    .euInValid, .euInData, .euInReady, .euOutValid, .euOutData, .euOutReady, .euIrq, .irqN
  );
  exec_unit_model #(.XorKey(XorKey)) eu_u (
    .clk_sys, .rst, .stall(euStall), .euInValid, .euInData, .euInReady, .euOutValid,
    .euOutData, .euOutReady
  );

  // ==========================================================================
  // Clock, randomness, helpers
  always #2 clk_sys = ~clk_sys;
  function automatic logic [WORD_W-1:0] nextRand();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState;
  endfunction : nextRand
  always @(posedge clk_sys) begin
    euStall <= lfsrState[2];
    void'(nextRand());
  end
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  initial begin
    repeat (50000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  // ==========================================================================
  // Host bus tasks: request held until an edge with ack
  task automatic beat(input logic w, input logic b, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] d, output logic [WORD_W-1:0] r);
    int n;
    n = 0;
    hostReq = 1'b1;
    hostWrite = w;
    hostBurst = b;
    hostAddr = a;
    hostWdata = d;
    #1;
    while (hostAck !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      finish_test();
    end else begin
      @(posedge clk_sys);
      #1;
      r = hostRdata;
    end
  endtask : beat
  task automatic idle();
    hostReq = 1'b0;
    hostBurst = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] r);
    beat(1'b0, 1'b0, a, 32'h0, r);
    idle();
  endtask : rd
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    logic [WORD_W-1:0] r;
    beat(1'b1, 1'b0, a, d, r);
    idle();
  endtask : wr
  task automatic burst(input logic w, input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] d, r;
    for (int i = 0; i < BURST_LEN; i++) begin
      d = nextRand();
      beat(w, i == 0, a, d, r);
      if (w) inQ.push_back(d);
      else check(r, inQ.pop_front() ^ XorKey);
    end
    idle();
  endtask : burst
  task automatic waitZero(input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] r;
    int n;
    n = 0;
    r = 32'h1;
    while (r !== 32'h0 && n < 300) begin
      rd(a, r);
      n++;
    end
    check(r, 32'h0);
    if (r !== 32'h0) finish_test();
  endtask : waitZero
  task automatic tryBurst(input logic [ADDR_W-1:0] a);
    hostReq = 1'b1;
    hostBurst = 1'b1;
    hostWrite = 1'b1;
    hostAddr = a;
    @(posedge clk_sys);
    #1;
    check({31'h0, hostRefused & ~hostAck}, 32'h1);
    idle();
  endtask : tryBurst

  // ==========================================================================
  // Main sequence
  initial begin
    logic [WORD_W-1:0] r;
    logic [EU_IRQ_W-1:0] irqv;
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    check({30'h0, dmaRequestOneN, dmaRequestTwoN}, 32'h1);
    rd(OFS_STATUS_CONFIG, r);
    check(r, 32'h0000_0012);
    for (int a = 3; a < 6; a++) begin
      rd(12'(a), r);
      check(r, 32'h0);
      wr(12'(a), 32'h0);
    end
    wr(12'h7ff, nextRand());
    rd(12'h7ff, r);
    check(r, 32'h0);
    tryBurst(OFS_STATUS_CONFIG);
    tryBurst(OFS_OUTPUT_BUF);
    for (int k = 0; k < BUF_DEPTH / BURST_LEN; k++) begin
      check(32'(dmaRequestOneN), 32'h0);
      burst(1'b1, OFS_INPUT_BUF);
    end
    // A full buffer must stall the writer, not drop the word
    hostReq = 1'b1;
    hostAddr = OFS_INPUT_BUF;
    repeat (3) @(posedge clk_sys);
    #1;
    check({31'h0, hostAck}, 32'h0);
    check(32'(dmaRequestOneN), 32'h1);
    idle();
    wr(OFS_INPUT_COUNT, 32'h0000_0010);
    wr(OFS_OUTPUT_COUNT, 32'h0000_0010);
    waitZero(OFS_INPUT_COUNT);
    waitZero(OFS_OUTPUT_COUNT);
    check({30'h0, dmaRequestOneN, dmaRequestTwoN}, 32'h0);
    rd(OFS_STATUS_CONFIG, r);
    check(r, 32'h0000_0012);
    burst(1'b0, OFS_OUTPUT_BUF);
    check(32'(dmaRequestTwoN), 32'h0);
    rd(OFS_OUTPUT_BUF, r);
    check(r, inQ.pop_front() ^ XorKey);
    check(32'(dmaRequestTwoN), 32'h1);
    wr(OFS_STATUS_CONFIG, 32'h0000_0001);
    check({30'h0, dmaRequestOneN, dmaRequestTwoN}, 32'h2);
    irqv = 5'(nextRand()) | 5'h01;
    euIrq = irqv;
    rd(OFS_STATUS_CONFIG, r);
    check(r, {19'h0, irqv, 8'h11});
    check(32'(irqN), 32'h0);
    wr(OFS_IRQ_MASK, 32'(irqv));
    check(32'(irqN), 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    euIrq = 5'h00;
    // Style pin only moves under reset
    rst = 1'b1;
    busStyle = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    tryBurst(OFS_INPUT_BUF);
    wr(OFS_INPUT_BUF, nextRand());
    rd(OFS_STATUS_CONFIG, r);
    check(r, 32'h0000_0002);
    check(32'(dmaRequestOneN), 32'h0);
    finish_test();
  end
endmodule : testbench

bind host_buffer_fifo_controller host_buffer_chk chk_u (
  .clk_sys, .rst, .busStyle, .hostReq, .hostWrite, .hostBurst, .hostAddr, .hostWdata,
  .hostAck, .hostRefused, .hostRvalid, .dmaRequestOneN, .dmaRequestTwoN, .euInValid,
  .euInReady, .euOutReady, .euIrq, .irqN
);
`default_nettype wire
